/* inc/smh_pkg.sv */
// constants, field layouts and carrier types of the serial master controller
package smh_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;          // sys_clk_i period
    localparam int DEV_CLK_NS_DEF = 125; // period of the far port's own cpu clock

    // ------------------------------------------------------------
    // command port
    // ------------------------------------------------------------
    localparam int BUS_AW = 2;
    localparam int BUS_DW = 16;
    localparam int BYTE_W = 8;
    localparam int DIV_W = 8;
    localparam logic [BUS_AW-1:0] ADDR_CTRL = 2'h0;
    localparam logic [BUS_AW-1:0] ADDR_TXD = 2'h1;
    localparam logic [BUS_AW-1:0] ADDR_RXD = 2'h2;
    localparam logic [BUS_AW-1:0] ADDR_STAT = 2'h3;
    localparam logic [BUS_DW-1:0] CTRL_RST = 16'h0400;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam int EDGE_W = 4;
    localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hf;
    localparam logic [EDGE_W:0] EDGES_PER_BYTE = 5'h10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DIV_W-1:0] half_div; // sck half period in sys clocks
        logic [3:0] rsvd;
        logic simplex;              // receive only over the tied data line
        logic hold;                 // keep select low between bytes (phase 1 only)
        logic cpha;
        logic cpol;
    } smh_cfg_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic mosi_oe;
        logic ss_n;
    } smh_pins_s;

    typedef struct packed {
        logic [BUS_DW-5:0] rsvd;
        logic refused;
        logic overrun;
        logic done;
        logic busy;
    } smh_stat_s;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP} smh_state_e;

endpackage

/* hdl/smh_tick_div.sv */
// half-period enable divider for the serial clock
`timescale 1ns/10ps
module smh_tick_div #(
    parameter int W = 8
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic [W-1:0] half_i,
    output logic tick_o
);

    logic [W-1:0] cnt_q;

    // one pulse every half_i cycles while running
    assign tick_o = run_i && (cnt_q == '0);

    // ------------------------------------------------------------
    // down counter, reloaded while stopped
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_q <= '0;
        else if (!run_i || cnt_q == '0)
            cnt_q <= half_i - W'(1);
        else
            cnt_q <= cnt_q - W'(1);
    end

endmodule // smh_tick_div

/* hdl/smh_master.sv */
// serial master controller driving the port as a slave
// Functional notes
// - sck half period at least far cpu period
// - bytes shifted most significant bit first
// - we alone start bytes and drive sck
// - simplex mode releases mosi, reads tied line
// - cpol and cpha chosen per byte, matching far
// - far master keeps internal select high
// - phase one may keep select low throughout
// - phase zero raises select between bytes
// - far software orders its register writes
// - far software enters slave mode properly
// - done flag cleared early, overrun otherwise flagged
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module smh_master #(
    parameter int DEV_CLK_NS = smh_pkg::DEV_CLK_NS_DEF
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [smh_pkg::BUS_AW-1:0] addr_i,
    input wire logic [smh_pkg::BUS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [smh_pkg::BUS_DW-1:0] rdata_o,
    output smh_pkg::smh_pins_s pins_o,
    input wire logic miso_i,
    input wire logic mosi_i
);
    import smh_pkg::*;

    // ------------------------------------------------------------
    // derived rate limit
    // ------------------------------------------------------------
    localparam int MIN_HALF_RAW = (DEV_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam int MIN_HALF = (MIN_HALF_RAW < 1) ? 1 : MIN_HALF_RAW;
    localparam logic [DIV_W-1:0] MIN_HALF_V = DIV_W'(MIN_HALF);

    smh_cfg_s cfg_q;
    smh_cfg_s act_q;
    smh_state_e state_q;
    logic [EDGE_W-1:0] cnt_q;
    logic sck_q;
    logic ss_n_q;
    logic [BYTE_W-1:0] tx_q;
    logic [BYTE_W-1:0] rx_sh_q;
    logic [BYTE_W-1:0] rxd_q;
    logic done_q;
    logic ovr_q;
    logic refused_q;
    logic [BUS_DW-1:0] rdata_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic tick;

    // ------------------------------------------------------------
    // pin synchronisers: bit 0 miso, bit 1 tied data line
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {mosi_i, miso_i};
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire logic wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    wire logic wr_txd = wr_i && (addr_i == ADDR_TXD);
    wire logic rd_rxd = rd_i && (addr_i == ADDR_RXD);
    wire logic rd_stat = rd_i && (addr_i == ADDR_STAT);
    wire logic idle = (state_q == ST_IDLE);
    wire logic start = wr_txd && idle;
    wire logic refused = wr_txd && !idle;
    wire logic in_shift = (state_q == ST_SHIFT);
    wire logic out_phase = cnt_q[0] ^ act_q.cpha;
    wire logic shift_now = in_shift && tick && out_phase && (cnt_q != '0);
    wire logic sample_now = in_shift && tick && !out_phase;
    wire logic rx_bit = act_q.simplex ? sync2_q[1] : sync2_q[0];
    wire logic byte_end = (state_q == ST_TRAIL) && tick;
    wire logic keep_sel = act_q.cpha && cfg_q.hold;
    wire logic [DIV_W-1:0] half_eff = (cfg_q.half_div < MIN_HALF_V) ? MIN_HALF_V : cfg_q.half_div;

    // ------------------------------------------------------------
    // configuration; active copy only follows while idle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cfg_q <= smh_cfg_s'(CTRL_RST);
        else if (wr_ctrl)
            cfg_q <= '{half_div: wdata_i[BUS_DW-1:BUS_DW-DIV_W], rsvd: '0, simplex: wdata_i[3],
                       hold: wdata_i[2], cpha: wdata_i[1], cpol: wdata_i[0]};
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            act_q <= smh_cfg_s'(CTRL_RST);
        else if (idle)
            act_q <= '{half_div: half_eff, rsvd: '0, simplex: cfg_q.simplex,
                       hold: cfg_q.hold, cpha: cfg_q.cpha, cpol: cfg_q.cpol};
    end

    // half period enable
    smh_tick_div #(
        .W(DIV_W)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .run_i(!idle),
        .half_i(act_q.half_div),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // byte sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE: if (start) state_q <= ST_LEAD;
                ST_LEAD: if (tick) state_q <= ST_SHIFT;
                ST_SHIFT: if (tick && cnt_q == EDGE_LAST) state_q <= ST_TRAIL;
                ST_TRAIL: if (tick) state_q <= keep_sel ? ST_IDLE : ST_GAP;
                ST_GAP: if (tick) state_q <= ST_IDLE;
            endcase
        end
    end

    // edge counter inside the byte
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_q <= '0;
        else if (!in_shift)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + EDGE_W'(1);
    end

    // serial clock: sixteen toggles per byte, rests at cpol
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sck_q <= 1'b0;
        else if (!in_shift)
            sck_q <= idle ? cfg_q.cpol : act_q.cpol;
        else if (tick)
            sck_q <= !sck_q;
    end

    // select: low from start, high after byte unless held
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ss_n_q <= 1'b1;
        else if (start)
            ss_n_q <= 1'b0;
        else if ((byte_end || idle) && !keep_sel)
            ss_n_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // data shifters
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_q <= '0;
        else if (start)
            tx_q <= wdata_i[BYTE_W-1:0];
        else if (shift_now)
            tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_sh_q <= '0;
        else if (sample_now)
            rx_sh_q <= {rx_sh_q[BYTE_W-2:0], rx_bit};
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rxd_q <= '0;
        else if (byte_end)
            rxd_q <= rx_sh_q;
    end

    // ------------------------------------------------------------
    // status flags; a set beats a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            done_q <= 1'b0;
            ovr_q <= 1'b0;
            refused_q <= 1'b0;
        end
        else
        begin
            done_q <= byte_end || (done_q && !rd_rxd);
            ovr_q <= (byte_end && done_q) || (ovr_q && !rd_stat);
            refused_q <= refused || (refused_q && !rd_stat);
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe only
    // ------------------------------------------------------------
    wire smh_stat_s stat_w = '{rsvd: '0, refused: refused_q, overrun: ovr_q, done: done_q, busy: !idle};
    wire logic [BUS_DW-1:0] rsel = (addr_i == ADDR_CTRL) ? BUS_DW'(cfg_q) :
                                   (addr_i == ADDR_RXD) ? BUS_DW'(rxd_q) :
                                   (addr_i == ADDR_STAT) ? BUS_DW'(stat_w) : '0;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_q <= '0;
        else
            rdata_q <= rd_i ? rsel : '0;
    end

    // outputs
    assign rdata_o = rdata_q;
    assign pins_o = '{sck: sck_q, mosi: tx_q[BYTE_W-1], mosi_oe: !act_q.simplex, ss_n: ss_n_q};

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    logic [DIV_W-1:0] gap_q;
    logic [EDGE_W:0] edges_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gap_q <= '1;
        else if (tick)
            gap_q <= '0;
        else if (gap_q != '1)
            gap_q <= gap_q + DIV_W'(1);
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            edges_q <= '0;
        else if (start)
            edges_q <= '0;
        else if (in_shift && tick)
            edges_q <= edges_q + (EDGE_W+1)'(1);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence byte_end_s;
        byte_end;
    endsequence

    sequence gap_after_s;
        ss_n_q && (state_q == ST_GAP);
    endsequence

    rate_gap_a: assert property (tick |-> (gap_q >= DIV_W'(MIN_HALF - 1)))
        else $error("sck half period shorter than allowed");
    msb_first_a: assert property (start |=> (pins_o.mosi == $past(wdata_i[BYTE_W-1])))
        else $error("first bit is not the msb");
    edge_count_a: assert property (byte_end_s |-> (edges_q == EDGES_PER_BYTE))
        else $error("byte did not carry sixteen sck edges");
    select_gap_a: assert property ((byte_end_s and !act_q.cpha) |=> gap_after_s)
        else $error("select not raised after phase zero byte");
    select_hold_a: assert property ((byte_end_s and keep_sel) |=> (!ss_n_q && idle))
        else $error("held select went high");
    oe_simplex_a: assert property ((idle && cfg_q.simplex) |=> !pins_o.mosi_oe)
        else $error("data line driven in simplex mode");
    sck_idle_a: assert property ((state_q == ST_LEAD || state_q == ST_GAP) |-> (sck_q == act_q.cpol))
        else $error("sck not at rest level");
    done_set_a: assert property (byte_end_s |=> done_q)
        else $error("done flag not set at byte end");
    ovr_set_a: assert property ((byte_end_s and done_q) |=> ovr_q)
        else $error("overrun not flagged");

endmodule // smh_master

/* tb/smh_dev_model.sv */
// behavioural far serial port acting as a slave
`timescale 1ns/10ps
module smh_dev_model (
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    logic [7:0] sh_q;
    int n_q;
    initial
    begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        n_q = 0;
    end
    // select edges: load reply in phase zero, invert the line between bytes
    always @(ss_n_i)
    begin
        n_q = 0;
        if (!ss_n_i && !cpha_i)
        begin
            sh_q = tx_i;
            miso_o = sh_q[7];
        end
        else if (ss_n_i)
            miso_o = ~miso_o; // inverted, not released
    end
    // clock edges: phase picks the sampling edge
    always @(sck_i)
    begin
        if (!ss_n_i)
        begin
            if ((sck_i != cpol_i) == !cpha_i)
            begin
                rx_o = {rx_o[6:0], mosi_i};
                n_q = (n_q == 7) ? 0 : n_q + 1;
            end
            else
            begin
                if (cpha_i && n_q == 0)
                    sh_q = tx_i;
                if (cpha_i)
                    miso_o = sh_q[7];
                sh_q = sh_q << 1;
                if (!cpha_i)
                    miso_o = sh_q[7];
            end
        end
    end
endmodule // smh_dev_model

/* tb/tb_smh_master.sv */
// self-checking bench of the serial master controller
`timescale 1ns/10ps
module tb_smh_master;
    import smh_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [BUS_AW-1:0] addr = '0;
    logic [BUS_DW-1:0] wdata = '0;
    logic [BUS_DW-1:0] rdata, st, acc;
    smh_pins_s pins;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic dev_miso, line;
    logic [7:0] dev_tx = 8'h00;
    logic [7:0] dev_rx, hd;
    logic [7:0] htab [4] = '{8'ha5, 8'h01, 8'h80, 8'h7e};
    logic [7:0] dtab [4] = '{8'h3c, 8'hfe, 8'h01, 8'hc3};
    int n_mismatch = 0;
    int total_checks = 0;
    int n_edge = 0;
    int cyc = 0;
    realtime t_last = 0;
    realtime t_min = 0;
    // tied data line in simplex
    assign line = pins.mosi_oe ? pins.mosi : dev_miso;
    smh_master u_smh_master (.sys_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pins_o(pins), .miso_i(dev_miso), .mosi_i(line));
    smh_dev_model u_smh_dev_model (.sck_i(pins.sck), .ss_n_i(pins.ss_n), .mosi_i(line), .cpol_i(cpol),
        .cpha_i(cpha), .tx_i(dev_tx), .miso_o(dev_miso), .rx_o(dev_rx));
    // clock generation
    initial
    begin
        forever #20 clk = ~clk;
    end
    // serial clock edge count and shortest half period
    always @(pins.sck)
    begin
        n_edge++;
        if ($realtime - t_last < t_min)
            t_min = $realtime - t_last;
        t_last = $realtime;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic wait_idle();
        acc = '0;
        st = 16'h0001;
        for (int i = 0; i < 400 && st[0] === 1'b1; i++)
        begin
            rd_reg(ADDR_STAT, st);
            acc = acc | st;
        end
    endtask
    task automatic xfer(input logic [7:0] htx, input logic [7:0] dtx);
        dev_tx = dtx;
        n_edge = 0;
        t_min = 1.0e9;
        wr_reg(ADDR_TXD, {8'h00, htx});
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(ADDR_CTRL, CTRL_RST);
        chk({12'h000, pins}, 16'h0003);
        wr_reg(ADDR_STAT, 16'hffff);
        rd_chk(ADDR_STAT, 16'h0000);
        // all four clock modes, one refused write each
        for (int m = 0; m < 4; m++)
        begin
            cpol = m[0];
            cpha = m[1];
            hd = (m == 0) ? 8'h01 : 8'h06;
            wr_reg(ADDR_CTRL, {hd, 6'h00, cpha, cpol});
            repeat (2) @(posedge clk);
            chk({15'h0000, pins.sck}, {15'h0000, cpol});
            xfer(htab[m], dtab[m]);
            wr_reg(ADDR_TXD, 16'h00ff);
            rd_chk(ADDR_STAT, 16'h0009);
            wait_idle();
            chk(st, 16'h0002);
            chk({8'h00, dev_rx}, {8'h00, htab[m]});
            rd_chk(ADDR_RXD, {8'h00, dtab[m]});
            rd_chk(ADDR_STAT, 16'h0000);
            chk(16'(n_edge), 16'h0010);
            chk({15'h0000, pins.sck}, {15'h0000, cpol});
            chk({15'h0000, pins.ss_n}, 16'h0001);
            chk(16'(int'(t_min)), 16'((hd < 8'h04 ? 4 : int'(hd)) * CLK_NS));
        end
        // two bytes without reading the first
        xfer(8'h11, 8'h22);
        wait_idle();
        xfer(8'h33, 8'h44);
        wait_idle();
        chk(acc & 16'h0006, 16'h0006);
        rd_chk(ADDR_RXD, 16'h0044);
        rd_chk(ADDR_STAT, 16'h0000);
        // select held low across bytes in phase one; far port set to the same mode
        cpol = 1'b0;
        cpha = 1'b1;
        wr_reg(ADDR_CTRL, 16'h0606);
        repeat (2) @(posedge clk);
        xfer(8'hc6, 8'h5b);
        wait_idle();
        chk({15'h0000, pins.ss_n}, 16'h0000);
        xfer(8'h39, 8'ha4);
        wait_idle();
        chk({8'h00, dev_rx}, 16'h0039);
        rd_chk(ADDR_RXD, 16'h00a4);
        wr_reg(ADDR_CTRL, 16'h0600);
        repeat (3) @(posedge clk);
        chk({15'h0000, pins.ss_n}, 16'h0001);
        // simplex receive over the tied line
        cpha = 1'b0;
        cpol = 1'b0;
        wr_reg(ADDR_CTRL, 16'h0408);
        repeat (3) @(posedge clk);
        chk({15'h0000, pins.mosi_oe}, 16'h0000);
        xfer(8'h00, 8'h96);
        wait_idle();
        rd_chk(ADDR_RXD, 16'h0096);
        rd_chk(ADDR_STAT, 16'h0000);
        finish_test();
    end
endmodule // tb_smh_master
